// ### qpwm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpwm_map.vh"
module qpwm_asserts (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic pwm_clk_req
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
      else $error("read answer missing");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not released");
   a_unmapped_read: assert property (s_ar_take ##0 s_axi_araddr == 8'hfc
      |=> s_axi_rresp == `QPWM_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_status_req: assert property (s_ar_take ##0 s_axi_araddr == `QPWM_OFS_REQ
      |=> s_axi_rdata[0] == $past(pwm_clk_req))
      else $error("status differs from clock request");
   a_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_write_release: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not released");
   a_req_cause: assert property ($changed(pwm_clk_req) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("clock request moved without a write");
endmodule
bind qpwm_top qpwm_asserts chk_u (.ref_clk(ref_clk), .nrst(nrst),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .pwm_clk_req(pwm_clk_req));
`default_nettype wire

// ### qpwm_map.vh
`ifndef QPWM_MAP_VH
`define QPWM_MAP_VH
`define QPWM_CH_STRIDE 8'h10
`define QPWM_OFS_START 8'h00
`define QPWM_OFS_THRESH 8'h04
`define QPWM_OFS_COUNT 8'h08
`define QPWM_OFS_CONFIG 8'h40
`define QPWM_OFS_ROUTE 8'h44
`define QPWM_OFS_REQ 8'h48
`define QPWM_CFG_EN 0
`define QPWM_CFG_CLK 4
`define QPWM_CFG_PHASE 8
`define QPWM_CNT_MAX 10'h3ff
`define QPWM_RESP_OKAY 2'b00
`define QPWM_RESP_SLVERR 2'b10
`define QPWM_REF_HZ 200000000
`define QPWM_LPO_HZ 128000
`define QPWM_SLOW_DIV 8'h08
`endif

// ### qpwm_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "qpwm_map.vh"
// Derives the 128 kHz peripheral tick and a slower tick from ref_clk.
// The oscillator divider only runs while clk_req is high, so ticks stop otherwise.
module qpwm_tick (
   input wire ref_clk,
   input wire nrst,
   input wire clk_req,
   output reg lpo_tick,
   output reg slow_tick
);
   localparam integer LPO_DIV = `QPWM_REF_HZ / `QPWM_LPO_HZ;
   localparam [10:0] LPO_LAST = LPO_DIV[10:0] - 11'h001;
   reg [10:0] div_cnt;
   reg [7:0] slow_cnt;
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt <= 11'h000;
         slow_cnt <= 8'h00;
         lpo_tick <= 1'b0;
         slow_tick <= 1'b0;
      end else if (!clk_req) begin
         div_cnt <= 11'h000;
         lpo_tick <= 1'b0;
         slow_tick <= 1'b0;
      end else if (div_cnt == LPO_LAST) begin
         div_cnt <= 11'h000;
         lpo_tick <= 1'b1;
         slow_tick <= (slow_cnt == `QPWM_SLOW_DIV - 8'h01);
         slow_cnt <= (slow_cnt == `QPWM_SLOW_DIV - 8'h01) ? 8'h00 : slow_cnt + 8'h01;
      end else begin
         div_cnt <= div_cnt + 11'h001;
         lpo_tick <= 1'b0;
         slow_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### qpwm_top.v
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "qpwm_map.vh"
module qpwm_top (
   input wire ref_clk,
   input wire nrst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg gpio_line_a,
   output reg gpio_line_b,
   output reg gpio_line_c,
   output reg gpio_line_d,
   output reg [3:0] gpio_line_oe,
   output reg pwm_clk_req
);
   reg [9:0] start_val [0:3];
   reg [9:0] thresh [0:3];
   reg [9:0] count [0:3];
   reg [3:0] wave;
   reg [11:0] chan_cfg;
   reg [3:0] route_en;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire lpo_tick;
   wire slow_tick;
   wire [3:0] enable = chan_cfg[`QPWM_CFG_EN +: 4];
   wire any_req = |enable;

   // Returns 1 when addr hits channel ch's register at ofs, otherwise 0.
   function hit_ch;
      input [7:0] addr;
      input [7:0] ofs;
      input [1:0] ch;
      begin
         hit_ch = (addr == ({6'h00, ch} << 4) + ofs);
      end
   endfunction

   // A mapped address is a channel register or one of the shared words.
   function is_mapped;
      input [7:0] addr;
      begin
         is_mapped = (addr[7:6] == 2'b00 && addr[3:0] <= 4'h8 && addr[1:0] == 2'b00 &&
            addr[3:2] != 2'b11) || addr == `QPWM_OFS_CONFIG || addr == `QPWM_OFS_ROUTE ||
            addr == `QPWM_OFS_REQ;
      end
   endfunction

   // Merges write data into an old value under the byte strobes.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = data[b*8 +: 8];
            end
         end
      end
   endfunction

   qpwm_tick u_tick (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .clk_req(pwm_clk_req),
      .lpo_tick(lpo_tick),
      .slow_tick(slow_tick)
   );

   // The request is registered, so the oscillator starts one cycle after an enable.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_clk_req <= 1'b0;
      end else begin
         pwm_clk_req <= any_req;
      end
   end

   // Write channel states, one-hot. Address and data may arrive in either order or together.
   localparam [4:0] WR_IDLE = 5'b00001;
   localparam [4:0] WR_ADDR = 5'b00010;
   localparam [4:0] WR_DATA = 5'b00100;
   localparam [4:0] WR_BOTH = 5'b01000;
   localparam [4:0] WR_RESP = 5'b10000;
   reg [4:0] wr_state;
   reg [4:0] next_wr_state;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire do_write = (wr_state == WR_BOTH);

   always @* begin
      next_wr_state = wr_state;
      case (wr_state)
         WR_IDLE: begin
            if (aw_take && w_take) begin
               next_wr_state = WR_BOTH;
            end else if (aw_take) begin
               next_wr_state = WR_ADDR;
            end else if (w_take) begin
               next_wr_state = WR_DATA;
            end
         end
         WR_ADDR: begin
            if (w_take) begin
               next_wr_state = WR_BOTH;
            end
         end
         WR_DATA: begin
            if (aw_take) begin
               next_wr_state = WR_BOTH;
            end
         end
         WR_BOTH: begin
            next_wr_state = WR_RESP;
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = WR_IDLE;
            end
         end
         default: begin
            next_wr_state = WR_IDLE;
         end
      endcase
   end

   // Each ready drops once its half is held, so a second address or word cannot overwrite it.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_state <= WR_IDLE;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `QPWM_RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         s_axi_awready <= (next_wr_state == WR_IDLE) || (next_wr_state == WR_DATA);
         s_axi_wready <= (next_wr_state == WR_IDLE) || (next_wr_state == WR_ADDR);
         s_axi_bvalid <= (next_wr_state == WR_RESP);
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bresp <= is_mapped(aw_addr) ? `QPWM_RESP_OKAY : `QPWM_RESP_SLVERR;
         end
      end
   end

   wire [31:0] cfg_m = merge({20'h00000, chan_cfg}, w_data, w_strb);
   wire [31:0] route_m = merge({28'h0000000, route_en}, w_data, w_strb);
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         chan_cfg <= 12'h000;
         route_en <= 4'h0;
      end else if (do_write) begin
         if (aw_addr == `QPWM_OFS_CONFIG) begin
            chan_cfg <= cfg_m[11:0];
         end
         if (aw_addr == `QPWM_OFS_ROUTE) begin
            route_en <= route_m[3:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : chan
         localparam [1:0] CH = g;
         wire [31:0] sv_m = merge({22'h000000, start_val[g]}, w_data, w_strb);
         wire [31:0] th_m = merge({22'h000000, thresh[g]}, w_data, w_strb);
         wire sel_slow = chan_cfg[`QPWM_CFG_CLK + g];
         wire tick = sel_slow ? slow_tick : lpo_tick;
         wire en = enable[g];
         reg en_d;
         reg [9:0] next_count;
         reg next_wave;
         always @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               start_val[g] <= 10'h000;
               thresh[g] <= 10'h000;
            end else if (do_write) begin
               if (hit_ch(aw_addr, `QPWM_OFS_START, CH)) begin
                  start_val[g] <= sv_m[9:0];
               end
               if (hit_ch(aw_addr, `QPWM_OFS_THRESH, CH)) begin
                  thresh[g] <= th_m[9:0];
               end
            end
         end
         // The count register has no write path at all.
         // Loading on the enable edge makes the first period start from the start value.
         always @* begin
            next_count = count[g];
            next_wave = wave[g];
            if (!en) begin
               next_wave = 1'b0;
            end else if (!en_d) begin
               next_count = start_val[g];
               next_wave = 1'b0;
            end else if (tick) begin
               if (count[g] == `QPWM_CNT_MAX) begin
                  next_count = start_val[g];
                  next_wave = 1'b0;
               end else begin
                  next_count = count[g] + 10'h001;
                  if (next_count == thresh[g]) begin
                     next_wave = ~wave[g];
                  end
               end
            end
         end
         always @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               count[g] <= 10'h000;
               wave[g] <= 1'b0;
               en_d <= 1'b0;
            end else begin
               en_d <= en;
               count[g] <= next_count;
               wave[g] <= next_wave;
            end
         end
      end
   endgenerate

   // Phase inversion is applied at the pin so the idle level follows it too.
   wire [3:0] pin_val = wave ^ chan_cfg[`QPWM_CFG_PHASE +: 4];
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gpio_line_a <= 1'b0;
         gpio_line_b <= 1'b0;
         gpio_line_c <= 1'b0;
         gpio_line_d <= 1'b0;
         gpio_line_oe <= 4'h0;
      end else begin
         gpio_line_a <= pin_val[0];
         gpio_line_b <= pin_val[1];
         gpio_line_c <= pin_val[2];
         gpio_line_d <= pin_val[3];
         gpio_line_oe <= route_en;
      end
   end

   reg [31:0] next_rdata;
   integer i;
   always @* begin
      next_rdata = 32'h0000_0000;
      for (i = 0; i < 4; i = i + 1) begin
         if (hit_ch(s_axi_araddr, `QPWM_OFS_START, i[1:0])) begin
            next_rdata = {22'h000000, start_val[i]};
         end
         if (hit_ch(s_axi_araddr, `QPWM_OFS_THRESH, i[1:0])) begin
            next_rdata = {22'h000000, thresh[i]};
         end
         if (hit_ch(s_axi_araddr, `QPWM_OFS_COUNT, i[1:0])) begin
            next_rdata = {22'h000000, count[i]};
         end
      end
      if (s_axi_araddr == `QPWM_OFS_CONFIG) begin
         next_rdata = {20'h00000, chan_cfg};
      end
      if (s_axi_araddr == `QPWM_OFS_ROUTE) begin
         next_rdata = {28'h0000000, route_en};
      end
      if (s_axi_araddr == `QPWM_OFS_REQ) begin
         next_rdata = {31'h00000000, pwm_clk_req};
      end
   end

   // Read channel states, one-hot: the answer always stands one cycle after the address.
   localparam [1:0] RD_IDLE = 2'b01;
   localparam [1:0] RD_RESP = 2'b10;
   reg [1:0] rd_state;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_state <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `QPWM_RESP_OKAY;
      end else begin
         case (rd_state)
            RD_IDLE: begin
               if (ar_take) begin
                  rd_state <= RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= next_rdata;
                  s_axi_rresp <= is_mapped(s_axi_araddr) ? `QPWM_RESP_OKAY : `QPWM_RESP_SLVERR;
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state <= RD_IDLE;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
            default: begin
               rd_state <= RD_IDLE;
               s_axi_rvalid <= 1'b0;
               s_axi_arready <= 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### qpwm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpwm_map.vh"
module qpwm_top_tb;
   localparam logic [1:0] OK = `QPWM_RESP_OKAY;
   localparam logic [1:0] ERR = `QPWM_RESP_SLVERR;
   localparam int SLOW_CYC = (`QPWM_REF_HZ / `QPWM_LPO_HZ) * `QPWM_SLOW_DIV;
   logic ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
   logic awready, wready, arready, line_a, line_b, line_c, line_d, clk_req;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, oe;
   logic [1:0] bresp, rresp;
   int fail_count = 0;
   int n_compared = 0;
   qpwm_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .gpio_line_a(line_a), .gpio_line_b(line_b), .gpio_line_c(line_c),
      .gpio_line_d(line_d), .gpio_line_oe(oe), .pwm_clk_req(clk_req));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Ready lines are held high throughout, so a task never re-drives them at an edge.
   // Bus waits have no limit of their own; the watchdog ends a hung handshake.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      check(32'(bresp), 32'(er));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      check(rdata, exp);
      check(32'(rresp), 32'(er));
   endtask
   task automatic wait_a(input logic v);
      int n;
      n = 0;
      while (line_a !== v && n < 4000) begin
         @(posedge ref_clk);
         n++;
      end
      check(32'(line_a), 32'(v));
   endtask
   task automatic t_regs;
      for (int ch = 0; ch < 4; ch++) begin
         wr(8'(ch * 16), 32'hffff_ffc0 + 32'(ch), OK);
         wr(8'(ch * 16) + `QPWM_OFS_THRESH, 32'h0000_0200 + 32'(ch), OK);
      end
      for (int ch = 0; ch < 4; ch++) begin
         rd_chk(8'(ch * 16), 32'h0000_03c0 + 32'(ch), OK);
         rd_chk(8'(ch * 16) + `QPWM_OFS_THRESH, 32'h0000_0200 + 32'(ch), OK);
      end
   endtask
   task automatic t_idle;
      wr(`QPWM_OFS_CONFIG, 32'hffff_f0f0, OK);
      rd_chk(`QPWM_OFS_CONFIG, 32'h0000_00f0, OK);
      wr(`QPWM_OFS_CONFIG, 32'h0000_0f00, OK);
      wr(8'h18, 32'h0000_0123, OK);
      rd_chk(8'h18, 32'h0, OK);
      check(32'({line_d, line_c, line_b, line_a}), 32'hf);
      check(32'(clk_req), 32'h0);
      rd_chk(`QPWM_OFS_REQ, 32'h0, OK);
   endtask
   task automatic t_run;
      wr(`QPWM_OFS_ROUTE, 32'h0000_000f, OK);
      @(posedge ref_clk);
      check(32'(oe), 32'hf);
      wr(8'h00, 32'h0000_03fd, OK);
      wr(`QPWM_OFS_THRESH, 32'h0000_03fe, OK);
      wr(`QPWM_OFS_CONFIG, 32'h0000_0001, OK);
      rd_chk(`QPWM_OFS_COUNT, 32'h0000_03fd, OK);
      check(32'(line_a), 32'h0);
      check(32'(clk_req), 32'h1);
      rd_chk(`QPWM_OFS_REQ, 32'h1, OK);
      wait_a(1'b1);
      rd_chk(`QPWM_OFS_COUNT, 32'h0000_03fe, OK);
      wait_a(1'b0);
      rd_chk(`QPWM_OFS_COUNT, 32'h0000_03fd, OK);
      rd_chk(8'h18, 32'h0, OK);
   endtask
   task automatic t_bad;
      rd_chk(8'hfc, 32'h0, ERR);
      wr(8'hfc, 32'hffff_ffff, ERR);
      rd_chk(`QPWM_OFS_CONFIG, 32'h0000_0001, OK);
   endtask
   // Channel 1 on the divided tick stays high for exactly one divided period.
   task automatic t_slow;
      int n;
      n = 0;
      wr(`QPWM_CH_STRIDE, 32'h0000_03fe, OK);
      wr(`QPWM_CH_STRIDE + `QPWM_OFS_THRESH, 32'h0000_03ff, OK);
      wr(`QPWM_OFS_CONFIG, 32'h0000_0023, OK);
      while (line_b !== 1'b1 && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      check(32'(line_b), 32'h1);
      n = 0;
      while (line_b !== 1'b0 && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      check(32'(n), SLOW_CYC);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      {nrst, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
      {bready, rready, wstrb} = 6'h3f;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_idle;
      t_run;
      t_bad;
      t_slow;
      finish_test;
   end
   initial begin
      #(80000 * 5);
      fail_count++;
      finish_test;
   end
endmodule
`default_nettype wire
